// [rtl/sd_port_pkg.sv]
// Constants and types shared by the sigma-delta bitstream port.
// Assumes a 20 MHz system clock; the link clock comes from the host.
package sd_port_pkg;

    // ------------------------------------------------------------------
    // Clocking
    // ------------------------------------------------------------------
    localparam int CLK_HZ         = 20_000_000;
    localparam int INT_CLK_LO_HZ  = 10_000_000;
    localparam int INT_CLK_HI_HZ  = 20_000_000;
    localparam int EXT_CLK_MIN_HZ = 5_000_000;
    localparam int EXT_CLK_MAX_HZ = 21_000_000;
    // A bit needs two system cycles at least, so the clock can toggle
    localparam int BIT_CYC_LO_RAW = CLK_HZ / INT_CLK_LO_HZ;
    localparam int BIT_CYC_HI_RAW = CLK_HZ / INT_CLK_HI_HZ;
    localparam int BIT_CYC_LO     = (BIT_CYC_LO_RAW < 2) ? 2 : BIT_CYC_LO_RAW;
    localparam int BIT_CYC_HI     = (BIT_CYC_HI_RAW < 2) ? 2 : BIT_CYC_HI_RAW;
    localparam int BIT_CNT_W      = 8;

    // ------------------------------------------------------------------
    // Modulator
    // ------------------------------------------------------------------
    localparam int SAMPLE_W  = 16;
    localparam int ACC_GUARD = 4;
    localparam int FIFO_W    = 1;
    localparam int FIFO_DEP  = 16;
    localparam logic FAIL_BIT    = 1'b1;
    localparam logic BIT_RESET   = 1'b0;
    localparam logic [2:0] VARIANT_CODE_RESET = 3'h0;

    // ------------------------------------------------------------------
    // Output variants
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        VAR_EXT_RISE,
        VAR_EXT_FALL,
        VAR_INT_MANCH,
        VAR_INT_RISE,
        VAR_INT_FALL
    } variant_t;

endpackage

// [rtl/bit_stream_if.sv]
// Valid/ready stream between the port logic and its FIFO.
// Assumes both ends sit on the same clock.
`timescale 1ns/10ps
interface bit_stream_if #(
    parameter int W = 1
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport source (output valid, output data, input  ready);
    modport sink   (input  valid, input  data, output ready);
endinterface

// [rtl/stream_fifo.sv]
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module stream_fifo #(
    parameter int W     = 1,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_sys_rst,
    // Streams
    bit_stream_if.sink      wr,
    bit_stream_if.source    rd
);
    import sd_port_pkg::*;

    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0]   cnt_reg, cnt_next;
    logic          push, pop;

    assign wr.ready = (cnt_reg != (AW+1)'(DEPTH));
    assign rd.valid = (cnt_reg != '0);
    assign rd.data  = mem[rp_reg];
    assign push     = wr.valid && wr.ready;
    assign pop      = rd.valid && rd.ready;

    always_comb begin
        wp_next  = push ? wp_reg + 1'b1 : wp_reg;
        rp_next  = pop  ? rp_reg + 1'b1 : rp_reg;
        cnt_next = cnt_reg;
        if (push && !pop) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wp_reg  <= wp_next;
            rp_reg  <= rp_next;
            cnt_reg <= cnt_next;
        end
    end

    // Storage carries no reset; only pointers define contents
    always_ff @(posedge i_clock) begin
        if (push) begin
            mem[wp_reg] <= wr.data;
        end
    end
endmodule

// [rtl/isolated_sigma_delta_bitstream_port.sv]
// Digital output side of an isolated second-order sigma-delta modulator.
// Assumes a sampled front-end word on i_clock, and a host link clock
// that may stop; strap and fault pins are asynchronous.
`timescale 1ns/10ps

// Overview of operation
// - Second-order loop turns each input sample into one stream bit.
// - External rising variant: launch on falling edge, host takes rising.
// - External falling variant: launch on rising edge, host takes falling.
// - Internal clock option is chosen by strap; at a 20 MHz system clock both settings give 2 cycles per bit, so 10 MHz.
// - Internal variants time every bit from the device's own clock.
// - Coded option sends Manchester bits: data and clock on one wire.
// - Uncoded internal options send raw bits plus a separate clock.
// - Overvoltage or supply loss forces a fixed pattern and fault flag.
module isolated_sigma_delta_bitstream_port (
    // System clock and reset
    input  wire logic                       i_clock,
    input  wire logic                       i_sys_rst,
    // Host link clock
    input  wire logic                       i_mod_clock,
    // Front end and diagnostics
    input  wire logic signed [sd_port_pkg::SAMPLE_W-1:0] i_sample,
    input  wire logic                       i_cm_overvoltage,
    input  wire logic                       i_hs_supply_lost,
    // Straps
    input  wire logic [2:0]                 i_variant_sel,
    input  wire logic                       i_int_clk_20m,
    // Output pins
    output logic                            o_bit_line,
    output logic                            o_bit_clock,
    output logic                            o_fault
);
    import sd_port_pkg::*;

    localparam int AW = SAMPLE_W + ACC_GUARD;
    localparam logic signed [AW-1:0] FB_POS =
        AW'((2 ** (SAMPLE_W - 1)) - 1);
    localparam logic signed [AW-1:0] FB_NEG = -FB_POS;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [5:0] pin_s1_reg, pin_s2_reg;

    always_ff @(posedge i_clock) begin
        pin_s1_reg <= {i_cm_overvoltage, i_hs_supply_lost,
                       i_variant_sel, i_int_clk_20m};
        pin_s2_reg <= pin_s1_reg;
    end

    // ------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------
    // Straps are sampled while reset is held so the variant cannot shift
    // under a running stream
    variant_t variant_reg, variant_next;
    logic     opt20_reg, opt20_next;

    always_comb begin
        variant_next = variant_reg;
        opt20_next   = opt20_reg;
        if (i_sys_rst) begin
            case (pin_s2_reg[3:1])
                3'h1:    variant_next = VAR_EXT_FALL;
                3'h2:    variant_next = VAR_INT_MANCH;
                3'h3:    variant_next = VAR_INT_RISE;
                3'h4:    variant_next = VAR_INT_FALL;
                default: variant_next = VAR_EXT_RISE;
            endcase
            opt20_next = pin_s2_reg[0];
        end
    end

    always_ff @(posedge i_clock) begin
        variant_reg <= variant_next;
        opt20_reg   <= opt20_next;
    end

    logic is_ext;
    assign is_ext = (variant_reg == VAR_EXT_RISE) ||
                    (variant_reg == VAR_EXT_FALL);

    // ------------------------------------------------------------------
    // Fail-safe diagnostics
    // ------------------------------------------------------------------
    logic fault_reg, fault_next;

    always_comb begin
        fault_next = pin_s2_reg[5] || pin_s2_reg[4];
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            fault_reg <= 1'b0;
        end else begin
            fault_reg <= fault_next;
        end
    end

    assign o_fault = fault_reg;

    // ------------------------------------------------------------------
    // Second-order modulator
    // ------------------------------------------------------------------
    bit_stream_if #(.W(FIFO_W)) push_if ();
    bit_stream_if #(.W(FIFO_W)) pop_if ();

    logic signed [AW-1:0] int1_reg, int1_next, int2_reg, int2_next;
    logic signed [AW-1:0] fb, x_ext;
    logic                 mod_bit;

    // The loop only advances on an accepted push, so back-pressure
    // from a slow link slows sampling instead of dropping bits
    always_comb begin
        x_ext     = AW'(i_sample);
        mod_bit   = ~int2_reg[AW-1];
        fb        = mod_bit ? FB_POS : FB_NEG;
        int1_next = int1_reg;
        int2_next = int2_reg;
        if (push_if.ready) begin
            int1_next = int1_reg + x_ext - fb;
            int2_next = int2_reg + int1_reg - fb;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            int1_reg <= '0;
            int2_reg <= '0;
        end else begin
            int1_reg <= int1_next;
            int2_reg <= int2_next;
        end
    end

    assign push_if.valid = !i_sys_rst;
    assign push_if.data  = fault_reg ? FAIL_BIT : mod_bit;

    stream_fifo #(
        .W     (FIFO_W),
        .DEPTH (FIFO_DEP)
    ) u_fifo (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .wr        (push_if),
        .rd        (pop_if)
    );

    // ------------------------------------------------------------------
    // Internal-clock bit timing
    // ------------------------------------------------------------------
    logic [BIT_CNT_W-1:0] bit_cyc, half_cyc;
    logic [BIT_CNT_W-1:0] phase_reg, phase_next;
    logic                 cur_bit_reg, cur_bit_next;
    logic                 line_reg, line_next;
    logic                 bclk_reg, bclk_next;
    logic                 boundary, int_pop;

    always_comb begin
        bit_cyc  = opt20_reg ? BIT_CNT_W'(BIT_CYC_HI)
                             : BIT_CNT_W'(BIT_CYC_LO);
        half_cyc = bit_cyc >> 1;
        boundary = (phase_reg == bit_cyc - 1'b1);
        int_pop  = !is_ext && boundary;
        phase_next = boundary ? '0 : phase_reg + 1'b1;
        cur_bit_next = cur_bit_reg;
        if (int_pop && pop_if.valid) begin
            cur_bit_next = pop_if.data[0];
        end
        line_next = 1'b0;
        bclk_next = 1'b0;
        case (variant_reg)
            VAR_INT_MANCH: begin
                // Low-to-high mid-bit means one
                line_next = (phase_next < half_cyc) ? ~cur_bit_next
                                                    : cur_bit_next;
            end
            VAR_INT_RISE: begin
                line_next = cur_bit_next;
                bclk_next = (phase_next >= half_cyc);
            end
            VAR_INT_FALL: begin
                line_next = cur_bit_next;
                bclk_next = (phase_next < half_cyc);
            end
            default: begin
                line_next = 1'b0;
                bclk_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            phase_reg   <= '0;
            cur_bit_reg <= BIT_RESET;
            line_reg    <= 1'b0;
            bclk_reg    <= 1'b0;
        end else begin
            phase_reg   <= phase_next;
            cur_bit_reg <= cur_bit_next;
            line_reg    <= line_next;
            bclk_reg    <= bclk_next;
        end
    end

    // ------------------------------------------------------------------
    // Handoff to the link domain
    // ------------------------------------------------------------------
    // One bit per toggle handshake; the link clock is far faster than
    // a handshake, so missing bits repeat the last one on the wire
    logic req_reg, req_next;
    logic xbit_reg, xbit_next;
    logic ack_s1_reg, ack_s2_reg;
    logic ext_pop, link_ack_reg;

    always_comb begin
        ext_pop   = is_ext && (req_reg == ack_s2_reg);
        req_next  = req_reg;
        xbit_next = xbit_reg;
        if (ext_pop && pop_if.valid) begin
            req_next  = ~req_reg;
            xbit_next = pop_if.data[0];
        end
    end

    always_ff @(posedge i_clock) begin
        ack_s1_reg <= link_ack_reg;
        ack_s2_reg <= ack_s1_reg;
        if (i_sys_rst) begin
            req_reg  <= 1'b0;
            xbit_reg <= BIT_RESET;
        end else begin
            req_reg  <= req_next;
            xbit_reg <= xbit_next;
        end
    end

    assign pop_if.ready = int_pop || ext_pop;

    // ------------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------------
    logic lrst_s1_reg, lrst_s2_reg;
    logic lreq_s1_reg, lreq_s2_reg;
    logic lstage_reg, lstage_next, link_ack_next;
    logic out_rise_reg, out_fall_reg;

    always_ff @(posedge i_mod_clock) begin
        lrst_s1_reg <= i_sys_rst;
        lrst_s2_reg <= lrst_s1_reg;
        lreq_s1_reg <= req_reg;
        lreq_s2_reg <= lreq_s1_reg;
    end

    // The data word is stable for the whole handshake, so sampling it
    // once the request is seen needs no extra synchroniser
    always_comb begin
        lstage_next   = lstage_reg;
        link_ack_next = link_ack_reg;
        if (lreq_s2_reg != link_ack_reg) begin
            lstage_next   = xbit_reg;
            link_ack_next = lreq_s2_reg;
        end
    end

    always_ff @(posedge i_mod_clock) begin
        if (lrst_s2_reg) begin
            lstage_reg   <= BIT_RESET;
            link_ack_reg <= 1'b0;
        end else begin
            lstage_reg   <= lstage_next;
            link_ack_reg <= link_ack_next;
        end
    end

    // Launched on falling edge so the host captures on the rising one
    always_ff @(negedge i_mod_clock) begin
        if (lrst_s2_reg) begin
            out_rise_reg <= BIT_RESET;
        end else begin
            out_rise_reg <= lstage_reg;
        end
    end

    // Launched on rising edge so the host captures on the falling one
    always_ff @(posedge i_mod_clock) begin
        if (lrst_s2_reg) begin
            out_fall_reg <= BIT_RESET;
        end else begin
            out_fall_reg <= lstage_reg;
        end
    end

    // ------------------------------------------------------------------
    // Pin mux
    // ------------------------------------------------------------------
    // Variant is fixed after reset, so the mux never switches mid-stream
    always_comb begin
        case (variant_reg)
            VAR_EXT_RISE: o_bit_line = out_rise_reg;
            VAR_EXT_FALL: o_bit_line = out_fall_reg;
            default:      o_bit_line = line_reg;
        endcase
    end

    assign o_bit_clock = bclk_reg;

endmodule

// [bench/sd_port_chk.sv]
// Assertions on the pins of the sigma-delta bitstream port.
// Assumes the variant strap is held steady for the whole run.
`timescale 1ns/10ps
module sd_port_chk (
    // Clocks and reset
    input  wire logic       i_clock,
    input  wire logic       i_sys_rst,
    input  wire logic       i_mod_clock,
    // Strap and fault pins
    input  wire logic [2:0] i_variant_sel,
    input  wire logic       i_cm_overvoltage,
    input  wire logic       i_hs_supply_lost,
    // Output pins
    input  wire logic       o_bit_line,
    input  wire logic       o_bit_clock,
    input  wire logic       o_fault
);
    logic [2:0] run_cnt_reg, run_cnt_next;
    logic [5:0] flt_cnt_reg, flt_cnt_next;
    logic       rise_line_reg, rise_line_next;
    logic       fall_line_reg, fall_line_next;
    logic       flt_pin;
    logic       settled;

    // Settling time covers the link-side reset copy
    always_comb begin
        flt_pin = i_cm_overvoltage | i_hs_supply_lost;
        settled = (run_cnt_reg == 3'h7);
        run_cnt_next = settled ? run_cnt_reg : run_cnt_reg + 3'h1;
        flt_cnt_next = (flt_cnt_reg == 6'h3F) ? flt_cnt_reg
                                              : flt_cnt_reg + 6'h1;
        if (!o_fault)
            flt_cnt_next = 6'h0;
        if (i_sys_rst) begin
            run_cnt_next = 3'h0;
            flt_cnt_next = 6'h0;
        end
        rise_line_next = o_bit_line;
        fall_line_next = o_bit_line;
    end
    always_ff @(posedge i_clock) begin
        run_cnt_reg <= run_cnt_next;
        flt_cnt_reg <= flt_cnt_next;
    end
    always_ff @(posedge i_mod_clock) rise_line_reg <= rise_line_next;
    always_ff @(negedge i_mod_clock) fall_line_reg <= fall_line_next;

    chk_reset_quiet: assert property (@(posedge i_clock)
        i_sys_rst ##1 i_sys_rst |-> !o_fault && !o_bit_clock)
        else $error("outputs not quiet in reset");
    chk_fault_raise: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) flt_pin [*4] |-> o_fault)
        else $error("fault flag late");
    chk_fault_drop: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) (!flt_pin) [*4] |-> !o_fault)
        else $error("fault flag stuck");
    chk_fault_ones: assert property (@(posedge i_clock)
        disable iff (i_sys_rst)
        flt_cnt_reg == 6'h3F && i_variant_sel == 3'h3 |-> o_bit_line)
        else $error("fault pattern not all ones");
    chk_clock_toggle: assert property (@(posedge i_clock)
        disable iff (i_sys_rst)
        settled && (i_variant_sel == 3'h3 || i_variant_sel == 3'h4)
        |-> o_bit_clock != $past(o_bit_clock))
        else $error("bit clock not toggling");
    chk_clock_idle: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) i_variant_sel < 3'h3 |-> !o_bit_clock)
        else $error("bit clock active in wrong variant");
    chk_manch_edges: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) settled && i_variant_sel == 3'h2
        |-> !(o_bit_line == $past(o_bit_line)
              && o_bit_line == $past(o_bit_line, 2)))
        else $error("coded line missing mid-bit edge");
    chk_rise_hold: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) settled && i_variant_sel == 3'h3
        && !$fell(o_bit_clock) |-> $stable(o_bit_line))
        else $error("data moved off falling clock");
    chk_fall_hold: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) settled && i_variant_sel == 3'h4
        && !$rose(o_bit_clock) |-> $stable(o_bit_line))
        else $error("data moved off rising clock");
    chk_ext_rise: assert property (@(negedge i_mod_clock)
        disable iff (i_sys_rst) settled && i_variant_sel == 3'h0
        |-> o_bit_line == rise_line_reg)
        else $error("data moved while link clock high");
    chk_ext_fall: assert property (@(posedge i_mod_clock)
        disable iff (i_sys_rst) settled && i_variant_sel == 3'h1
        |-> o_bit_line == fall_line_reg)
        else $error("data moved while link clock low");
endmodule

// [bench/sinc_host_model.sv]
// Host receiver in front of the decimation filter: makes the link
// clock and tallies the captured bits. Assumes variant codes 0 to 4.
`timescale 1ns/10ps
module sinc_host_model (
    // Variant and pins
    input  wire logic [2:0] i_variant_sel,
    input  wire logic       i_bit_line,
    input  wire logic       i_bit_clock,
    // Link clock and tallies
    output logic            o_mod_clock,
    output int              o_bits,
    output int              o_ones
);
    logic cap_clk;
    logic man_prev = 1'b0;
    int   man_gap  = 0;

    // Link clock runs free; far faster than bits, so each is seen often
    initial begin
        o_mod_clock = 1'b0;
        o_bits = 0;
        o_ones = 0;
        #1.3;
        forever #3 o_mod_clock = ~o_mod_clock;
    end
    assign cap_clk = (i_variant_sel < 3'h2) ? o_mod_clock : i_bit_clock;

    always @(posedge cap_clk) begin
        if (i_variant_sel == 3'h0 || i_variant_sel == 3'h3) begin
            o_bits++;
            o_ones += int'(i_bit_line);
        end
    end
    always @(negedge cap_clk) begin
        if (i_variant_sel == 3'h1 || i_variant_sel == 3'h4) begin
            o_bits++;
            o_ones += int'(i_bit_line);
        end
    end
    // Coded line: a mid-bit edge is the first edge well past half a bit
    // after the last one, so boundary edges between equal bits are skipped
    always @(posedge o_mod_clock) begin
        if (i_variant_sel == 3'h2 && i_bit_line != man_prev
            && man_gap >= 12) begin
            o_bits++;
            o_ones += int'(i_bit_line);
            man_gap = 0;
        end else if (man_gap < 100) begin
            man_gap++;
        end
        man_prev = i_bit_line;
    end
endmodule

// [bench/isolated_sigma_delta_bitstream_port_tb.sv]
// Self-checking bench for the sigma-delta bitstream port.
// Assumes the host model supplies the link clock and bit tallies.
`timescale 1ns/10ps
module isolated_sigma_delta_bitstream_port_tb;
    import sd_port_pkg::*;
    typedef struct {
        logic [2:0]         var_sel;
        logic               fast;
        logic signed [15:0] smp;
        int                 pct;
    } row_t;
    row_t rows [8] = '{
        '{3'h0, 1'b0, 16'sh6000, 87}, '{3'h0, 1'b1, -16'sh6000, 13},
        '{3'h1, 1'b1, 16'sh6000, 87}, '{3'h1, 1'b0, -16'sh6000, 13},
        '{3'h3, 1'b0, 16'sh6000, 87}, '{3'h3, 1'b1, -16'sh6000, 13},
        '{3'h4, 1'b1, 16'sh6000, 87}, '{3'h4, 1'b0, -16'sh6000, 13}};
    logic clk = 1'b0, rst = 1'b1, ov = 1'b0, hs = 1'b0, fast = 1'b0;
    logic signed [15:0] smp = 16'sh0;
    logic [2:0] var_sel = 3'h0;
    logic line, bclk, flt, mclk, prev;
    int bits, ones, b0, o0, nb, no, n, error_cnt = 0, checks = 0;

    initial forever #25 clk = ~clk;

    isolated_sigma_delta_bitstream_port i_isolated_sigma_delta_bitstream_port (
        .i_clock(clk), .i_sys_rst(rst), .i_mod_clock(mclk), .i_sample(smp),
        .i_cm_overvoltage(ov), .i_hs_supply_lost(hs), .i_variant_sel(var_sel),
        .i_int_clk_20m(fast), .o_bit_line(line), .o_bit_clock(bclk),
        .o_fault(flt));
    sinc_host_model i_sinc_host_model (.i_variant_sel(var_sel),
        .i_bit_line(line), .i_bit_clock(bclk), .o_mod_clock(mclk),
        .o_bits(bits), .o_ones(ones));

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Straps are taken while reset is high, so each variant needs one
    task automatic do_reset();
        rst = 1'b1;
        repeat (8) @(negedge clk);
        check({13'h0, flt, bclk, line}, 16'h0);
        rst = 1'b0;
        repeat (20) @(negedge clk);
    endtask
    task automatic tally(input int cyc);
        b0 = bits;
        o0 = ones;
        repeat (cyc) @(negedge clk);
        nb = bits - b0;
        no = ones - o0;
    endtask

    initial begin
        // ------------------------------------------------------------
        // Stream density per uncoded variant
        // ------------------------------------------------------------
        foreach (rows[r]) begin
            var_sel = rows[r].var_sel;
            fast = rows[r].fast;
            smp = rows[r].smp;
            do_reset();
            tally(400);
            checks++;
            if (nb < 50 || no * 100 > nb * (rows[r].pct + 12)
                || no * 100 < nb * (rows[r].pct - 12)) begin
                error_cnt++;
                $display("wrong value at %0t: got %h expected %h",
                         $time, no, nb * rows[r].pct / 100);
            end
            $display("row %0d done", r);
        end
        // ------------------------------------------------------------
        // Coded line: an edge in every bit
        // ------------------------------------------------------------
        var_sel = 3'h2;
        do_reset();
        prev = line;
        n = 0;
        repeat (200) begin
            @(negedge clk);
            if (line !== prev)
                n++;
            prev = line;
        end
        check(16'(n >= 100), 16'h1);
        tally(400);
        check(16'(nb >= 150 && no * 100 <= nb * 25), 16'h1);
        $display("coded test done");
        // ------------------------------------------------------------
        // Fault mid-stream; latency, pattern, hand-over, clear
        // ------------------------------------------------------------
        var_sel = 3'h3;
        smp = -16'sh6000;
        do_reset();
        ov = 1'b1;
        n = 0;
        while (flt !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        if (n == 10) begin
            error_cnt++;
        end else begin
            check(16'(n), 16'h3);
        end
        repeat (80) @(negedge clk);
        tally(100);
        check(16'(no), 16'(nb));
        ov = 1'b0;
        hs = 1'b1;
        repeat (5) @(negedge clk);
        check({15'h0, flt}, 16'h1);
        hs = 1'b0;
        repeat (5) @(negedge clk);
        check({15'h0, flt}, 16'h0);
        $display("fault test done");
        tally_and_finish();
    end
endmodule

bind isolated_sigma_delta_bitstream_port sd_port_chk i_sd_port_chk (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_mod_clock(i_mod_clock),
    .i_variant_sel(i_variant_sel), .i_cm_overvoltage(i_cm_overvoltage),
    .i_hs_supply_lost(i_hs_supply_lost), .o_bit_line(o_bit_line),
    .o_bit_clock(o_bit_clock), .o_fault(o_fault));
